// file: pci_host_pkg.sv
// shared types and constants for the host-side bus controller
package pci_host_pkg;

    // ---------------------------------------------
    // bus command codes (low bit set means write)
    // ---------------------------------------------
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [2:0] CFG_CODE_HI = 3'h5;

    // ---------------------------------------------
    // timing counts and reset values
    // ---------------------------------------------
    localparam logic [2:0] DEVSEL_WAIT = 3'h5; // clocks before master abort
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam logic [31:0] AD_RST = 32'h0000_0000;

    // ---------------------------------------------
    // answer kinds on the response stream
    // ---------------------------------------------
    localparam logic [1:0] RK_DONE = 2'h0;
    localparam logic [1:0] RK_RETRY = 2'h1;
    localparam logic [1:0] RK_ABORT = 2'h2;
    localparam logic [1:0] RK_TWRITE = 2'h3;

    typedef struct packed {
        logic [3:0] code;
        logic [3:0] be_n;
        logic [31:0] addr;
        logic [31:0] data;
    } cmd_t;

    typedef struct packed {
        logic [1:0] kind;
        logic [31:0] data;
    } resp_t;

    typedef enum logic [2:0] {M_IDLE, M_ADDR, M_DATA, M_TURN, M_GRANT} mst_t;
    typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} tgt_t;

    function automatic logic is_write(input logic [3:0] code);
        return code[0];
    endfunction

    function automatic logic is_cfg(input logic [3:0] code);
        return code[3:1] == CFG_CODE_HI;
    endfunction

endpackage

// file: pci_rsp_buf.sv
// two-entry response buffer between bus and user stream
`timescale 1ns/1ps
module pci_rsp_buf (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire pci_host_pkg::resp_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output pci_host_pkg::resp_t out_data
);
    // ---------------------------------------------
    // storage
    // ---------------------------------------------
    pci_host_pkg::resp_t e0_q;
    pci_host_pkg::resp_t e1_q;
    logic [1:0] cnt_q;

    // full refuses a push even when popping, keeps ready off the pop path
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt_q != pci_host_pkg::BUF_DEPTH;
    assign out_valid = cnt_q != 2'h0;
    assign out_data = e0_q;

    // shift on pop, fill the first free slot on push
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q <= 2'h0;
            e0_q <= '0;
            e1_q <= '0;
        end else begin
            if (pop && (cnt_q == 2'h2)) e0_q <= e1_q;
            if (push && (cnt_q == 2'h0 || (pop && cnt_q == 2'h1))) e0_q <= in_data;
            if (push && ((cnt_q == 2'h1 && !pop) || cnt_q == 2'h2)) e1_q <= in_data;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// file: pci_par_gen.sv
// even parity one clock after the phase, plus check of the far side
`timescale 1ns/1ps
module pci_par_gen (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [31:0] ad,
    input wire logic [3:0] cbe_n,
    input wire logic drive,
    input wire logic check,
    input wire logic par_i,
    output logic par_o,
    output logic par_oe,
    output logic perr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ---------------------------------------------
    // parity launch and compare
    // ---------------------------------------------
    logic chk_q;
    wire par_now = ^{ad, cbe_n};

    // comparing on the next clock lines up with the late bit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            par_o <= 1'b0;
            par_oe <= 1'b0;
            chk_q <= 1'b0;
            perr <= 1'b0;
        end else begin
            par_o <= par_now;
            par_oe <= drive;
            chk_q <= check;
            perr <= chk_q && (par_i != par_o);
        end
    end

    a_par_even: assert property (par_oe |-> !(^{par_o, $past(ad), $past(cbe_n)}))
        else $error("parity not even over its phase");
    a_par_late: assert property (drive |=> par_oe)
        else $error("parity not presented one clock after phase");
endmodule

// file: pci_host_ctrl.sv
// host-side bus initiator, arbiter and target for the audio device
`timescale 1ns/1ps
module pci_host_ctrl (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire pci_host_pkg::cmd_t cmd,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output pci_host_pkg::resp_t rsp,
    input wire logic [31:0] tgt_rdata,
    output logic irq,
    output logic par_err,
    input wire logic [31:0] ad_i,
    output logic [31:0] ad_o,
    output logic ad_oe,
    input wire logic [3:0] cbe_n_i,
    output logic [3:0] cbe_n_o,
    output logic cbe_n_oe,
    input wire logic par_i,
    output logic par_o,
    output logic par_oe,
    input wire logic frame_n_i,
    output logic frame_n_o,
    output logic frame_n_oe,
    input wire logic irdy_n_i,
    output logic irdy_n_o,
    output logic irdy_n_oe,
    input wire logic trdy_n_i,
    output logic trdy_n_o,
    output logic trdy_n_oe,
    input wire logic stop_n_i,
    output logic stop_n_o,
    output logic stop_n_oe,
    input wire logic devsel_n_i,
    output logic devsel_n_o,
    output logic devsel_n_oe,
    output logic idsel,
    input wire logic req_n,
    output logic gnt_n,
    input wire logic inta_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ---------------------------------------------
    // state
    // ---------------------------------------------
    pci_host_pkg::mst_t st_q;
    pci_host_pkg::mst_t st_d;
    pci_host_pkg::tgt_t t_st_q;
    pci_host_pkg::tgt_t t_st_d;
    pci_host_pkg::cmd_t cmd_q;
    logic [3:0] t_code_q;
    logic t_first_q;
    logic [31:0] t_rd_q;
    logic [2:0] wait_q;
    logic req_s1_q;
    logic req_s2_q;
    logic int_s1_q;
    logic int_s2_q;
    logic buf_in_ready;
    pci_host_pkg::resp_t buf_in;

    // ---------------------------------------------
    // request and interrupt pins are not bus-timed
    // ---------------------------------------------
    // two flops each: request floats in reset and the interrupt is a slow level
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_s1_q <= 1'b1;
            req_s2_q <= 1'b1;
            int_s1_q <= 1'b1;
            int_s2_q <= 1'b1;
        end else begin
            req_s1_q <= req_n;
            req_s2_q <= req_s1_q;
            int_s1_q <= inta_n;
            int_s2_q <= int_s1_q;
        end
    end
    assign irq = !int_s2_q;

    // ---------------------------------------------
    // decode of bus conditions
    // ---------------------------------------------
    wire dev_req = !req_s2_q;
    wire bus_idle = frame_n_i && irdy_n_i;
    wire take_dev = dev_req && bus_idle;
    wire m_wr = pci_host_pkg::is_write(cmd_q.code);
    wire m_ready = (st_q == pci_host_pkg::M_DATA) && buf_in_ready;
    wire m_done = m_ready && !trdy_n_i;
    wire m_stop = m_ready && trdy_n_i && !stop_n_i;
    wire m_abort = m_ready && devsel_n_i && (wait_q == pci_host_pkg::DEVSEL_WAIT);
    wire t_wr = pci_host_pkg::is_write(t_code_q);
    wire t_start = (st_q == pci_host_pkg::M_GRANT) && (t_st_q == pci_host_pkg::T_IDLE)
        && !frame_n_i && irdy_n_i;
    wire t_ready = (t_st_q == pci_host_pkg::T_DATA) && !t_first_q && (!t_wr || buf_in_ready);
    wire t_beat = t_ready && !irdy_n_i;
    wire t_push = t_beat && t_wr;
    wire t_drive = (t_st_q == pci_host_pkg::T_DATA) && !t_first_q && !t_wr;

    assign cmd_ready = (st_q == pci_host_pkg::M_IDLE) && !take_dev;

    // ---------------------------------------------
    // master and grant sequencing
    // ---------------------------------------------
    // the device gets the bus first; a host command waits while it is granted
    always_comb begin
        st_d = st_q;
        case (st_q)
            pci_host_pkg::M_IDLE: begin
                if (take_dev) st_d = pci_host_pkg::M_GRANT;
                else if (cmd_valid) st_d = pci_host_pkg::M_ADDR;
            end
            pci_host_pkg::M_ADDR: st_d = pci_host_pkg::M_DATA;
            pci_host_pkg::M_DATA: begin
                if (m_done || m_stop || m_abort) st_d = pci_host_pkg::M_TURN;
            end
            pci_host_pkg::M_TURN: st_d = pci_host_pkg::M_IDLE;
            pci_host_pkg::M_GRANT: begin
                if (!dev_req && bus_idle && t_st_q == pci_host_pkg::T_IDLE) st_d = pci_host_pkg::M_IDLE;
            end
            default: st_d = pci_host_pkg::M_IDLE;
        endcase
    end

    // ---------------------------------------------
    // target sequencing while the device masters
    // ---------------------------------------------
    // every cycle the device starts is claimed: it only ever targets host memory
    always_comb begin
        t_st_d = t_st_q;
        case (t_st_q)
            pci_host_pkg::T_IDLE: begin
                if (t_start) t_st_d = pci_host_pkg::T_DATA;
            end
            pci_host_pkg::T_DATA: begin
                if (t_beat && frame_n_i) t_st_d = pci_host_pkg::T_TURN;
            end
            pci_host_pkg::T_TURN: t_st_d = pci_host_pkg::T_IDLE;
            default: t_st_d = pci_host_pkg::T_IDLE;
        endcase
    end

    // state registers and captured phase values
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= pci_host_pkg::M_IDLE;
            t_st_q <= pci_host_pkg::T_IDLE;
            cmd_q <= '0;
            t_code_q <= 4'h0;
            t_first_q <= 1'b0;
            t_rd_q <= pci_host_pkg::AD_RST;
            wait_q <= 3'h0;
        end else begin
            st_q <= st_d;
            t_st_q <= t_st_d;
            t_rd_q <= tgt_rdata;
            if (cmd_valid && cmd_ready) cmd_q <= cmd;
            if (t_start) t_code_q <= cbe_n_i;
            t_first_q <= t_start; // turnaround before driving read data
            if (st_q != pci_host_pkg::M_DATA) wait_q <= 3'h0;
            else if (devsel_n_i && wait_q != pci_host_pkg::DEVSEL_WAIT) wait_q <= wait_q + 3'h1;
        end
    end

    // ---------------------------------------------
    // pin drive
    // ---------------------------------------------
    // address, then write data, share the lines; target read data last
    assign ad_oe = (st_q == pci_host_pkg::M_ADDR) || (st_q == pci_host_pkg::M_DATA && m_wr)
        || t_drive;
    assign ad_o = (st_q == pci_host_pkg::M_ADDR) ? cmd_q.addr
        : (st_q == pci_host_pkg::M_DATA) ? cmd_q.data : t_rd_q;
    assign cbe_n_oe = (st_q == pci_host_pkg::M_ADDR) || (st_q == pci_host_pkg::M_DATA);
    assign cbe_n_o = (st_q == pci_host_pkg::M_ADDR) ? cmd_q.code : cmd_q.be_n;
    // single data phase: frame falls back as initiator ready comes on
    assign frame_n_oe = (st_q == pci_host_pkg::M_ADDR) || (st_q == pci_host_pkg::M_DATA)
        || (st_q == pci_host_pkg::M_TURN);
    assign frame_n_o = st_q != pci_host_pkg::M_ADDR;
    assign irdy_n_oe = (st_q == pci_host_pkg::M_DATA) || (st_q == pci_host_pkg::M_TURN);
    assign irdy_n_o = !m_ready;
    assign idsel = (st_q == pci_host_pkg::M_ADDR) && pci_host_pkg::is_cfg(cmd_q.code);
    assign gnt_n = st_q != pci_host_pkg::M_GRANT;
    assign devsel_n_oe = t_st_q != pci_host_pkg::T_IDLE;
    assign devsel_n_o = t_st_q != pci_host_pkg::T_DATA;
    assign trdy_n_oe = devsel_n_oe;
    assign trdy_n_o = !t_ready;
    assign stop_n_oe = devsel_n_oe;
    assign stop_n_o = 1'b1; // never stops the device; stalls with target ready instead

    // ---------------------------------------------
    // answers into the buffer
    // ---------------------------------------------
    // master and target phases never overlap, so one input port serves both
    always_comb begin
        buf_in.kind = pci_host_pkg::RK_TWRITE;
        buf_in.data = ad_i;
        if (m_done) begin
            buf_in.kind = pci_host_pkg::RK_DONE;
            buf_in.data = m_wr ? cmd_q.data : ad_i;
        end else if (m_stop) begin
            buf_in.kind = pci_host_pkg::RK_RETRY;
        end else if (m_abort) begin
            buf_in.kind = pci_host_pkg::RK_ABORT;
        end
    end

    pci_rsp_buf u_buf (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(m_done || m_stop || m_abort || t_push),
        .in_ready(buf_in_ready),
        .in_data(buf_in),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready),
        .out_data(rsp)
    );

    pci_par_gen u_par (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ad(ad_i),
        .cbe_n(cbe_n_i),
        .drive(ad_oe),
        .check(t_start || t_push || (m_done && !m_wr)),
        .par_i(par_i),
        .par_o(par_o),
        .par_oe(par_oe),
        .perr(par_err)
    );

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    a_addr_phase: assert property ((st_q == pci_host_pkg::M_ADDR) |-> ad_oe && ad_o == cmd_q.addr
        && cbe_n_o == cmd_q.code ##1 cbe_n_o == cmd_q.be_n)
        else $error("address phase lines wrong");
    a_frame_hold: assert property ($rose(st_q == pci_host_pkg::M_ADDR) |-> !frame_n_o && frame_n_oe
        ##1 irdy_n_oe && frame_n_oe)
        else $error("frame not held over transaction");
    a_irdy_room: assert property (!irdy_n_o && irdy_n_oe |-> buf_in_ready)
        else $error("initiator ready without room");
    a_stop_ends: assert property (m_stop |=> st_q == pci_host_pkg::M_TURN ##1 !frame_n_oe)
        else $error("stop did not end transaction");
    a_idsel_cfg: assert property (idsel |-> pci_host_pkg::is_cfg(cbe_n_o) && !frame_n_o)
        else $error("config select outside config address");
    a_trdy_claim: assert property (!trdy_n_o && trdy_n_oe |-> !devsel_n_o && $past(devsel_n_oe))
        else $error("target ready before claim");
    a_abort_bound: assert property ((st_q == pci_host_pkg::M_DATA) |-> wait_q <= pci_host_pkg::DEVSEL_WAIT)
        else $error("claim wait exceeded");
    a_no_cbe_tgt: assert property ((t_st_q != pci_host_pkg::T_IDLE) |-> !cbe_n_oe && gnt_n == 1'b0)
        else $error("command lines driven while device masters");
    a_irq_sync: assert property (!inta_n [*3] |-> irq)
        else $error("interrupt level not followed");
endmodule

// file: pci_dev_model.sv
// behavioural model of the audio device facing the host controller
`timescale 1ns/1ps
module pci_dev_model #(
    parameter logic [15:0] BASE_HI = 16'hC000
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [31:0] ad,
    input wire logic [3:0] cbe_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic trdy_n,
    input wire logic idsel,
    input wire logic gnt_n,
    input wire logic [1:0] mode, // 0 prompt, 1 slow, 2 retry, 3 deaf
    input wire logic go,
    input wire logic go_wr,
    input wire logic [31:0] go_addr,
    input wire logic [31:0] go_data,
    input wire logic [31:0] rdata,
    input wire logic irq_set,
    output logic [31:0] ad_o,
    output logic ad_oe,
    output logic [3:0] cbe_n_o,
    output logic cbe_oe,
    output logic par_o,
    output logic par_oe,
    output logic [4:0] ctl_n, // frame irdy trdy stop devsel
    output logic [4:0] ctl_oe,
    output logic req_n,
    output logic inta_n,
    output logic [31:0] got,
    output logic busy
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic [2:0] st_q;
    logic [1:0] wait_q;
    logic wr_q;
    logic cfg_w;
    logic hit_w;
    // config space answers on idsel alone, never by address range
    assign cfg_w = cbe_n[3:1] == pci_host_pkg::CFG_CODE_HI;
    assign hit_w = !frame_n && irdy_n && mode != 2'h3 && (cfg_w ? idsel : ad[31:16] == BASE_HI);
    assign busy = st_q != 3'h0 || !req_n;
    assign inta_n = !irq_set;
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // every line changes just after the rising edge
    always_ff @(posedge ref_clk) begin
        par_oe <= ad_oe;
        par_o <= ^{ad, cbe_n};
        if (!rst_n) begin
            st_q <= 3'h0;
            ad_oe <= 1'b0;
            cbe_oe <= 1'b0;
            ctl_oe <= 5'h00;
            ctl_n <= 5'h1F;
            req_n <= 1'b1;
            par_oe <= 1'b0;
        end else begin
            if (go) req_n <= 1'b0;
            case (st_q)
                3'h0: begin
                    if (hit_w) begin
                        st_q <= 3'h1;
                        wr_q <= cbe_n[0];
                        wait_q <= mode == 2'h1 ? 2'h3 : 2'h0;
                        ctl_n[2:0] <= 3'b110;
                        ctl_oe[2:0] <= 3'b111;
                    end else if (!req_n && !gnt_n && frame_n && irdy_n) begin
                        st_q <= 3'h4;
                        ctl_n[4:3] <= 2'b01;
                        ctl_oe[4:3] <= 2'b11;
                        ad_o <= go_addr;
                        ad_oe <= 1'b1;
                        cbe_n_o <= go_wr ? pci_host_pkg::CMD_MEM_WR : pci_host_pkg::CMD_MEM_RD;
                        cbe_oe <= 1'b1;
                    end
                end
                3'h1: begin
                    if (mode == 2'h2) begin
                        ctl_n[1] <= 1'b0;
                        st_q <= 3'h2;
                    end else if (wait_q != 2'h0) begin
                        wait_q <= wait_q - 2'h1;
                    end else begin
                        ctl_n[2] <= 1'b0;
                        ad_o <= rdata;
                        ad_oe <= !wr_q;
                        st_q <= 3'h2;
                    end
                end
                3'h2: begin
                    if (!irdy_n) begin
                        got <= ad;
                        ctl_n[2:0] <= 3'b111;
                        ad_oe <= 1'b0;
                        st_q <= 3'h3;
                    end
                end
                3'h4: begin
                    ctl_n[4:3] <= 2'b10;
                    cbe_n_o <= 4'h0;
                    ad_o <= go_data;
                    ad_oe <= go_wr;
                    st_q <= 3'h5;
                end
                3'h5: begin
                    if (!trdy_n) begin
                        got <= ad;
                        ctl_n[3] <= 1'b1;
                        ad_oe <= 1'b0;
                        cbe_oe <= 1'b0;
                        req_n <= 1'b1;
                        st_q <= 3'h3;
                    end
                end
                // lines were driven high one cycle, now released
                default: begin
                    ctl_oe <= 5'h00;
                    st_q <= 3'h0;
                end
            endcase
        end
    end
endmodule

// file: tb.sv
// self-checking bench for the host-side bus controller
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic rsp_ready = 1'b0;
    pci_host_pkg::cmd_t cmd = '0;
    pci_host_pkg::resp_t rsp;
    logic [31:0] tgt_rdata = 32'h0000_0000;
    logic [31:0] rdata = 32'h0000_0000;
    logic [31:0] go_addr = 32'h0000_0000;
    logic [31:0] go_data = 32'h0000_0000;
    logic [1:0] mode = 2'h0;
    logic go = 1'b0, go_wr = 1'b0, irq_set = 1'b0, gnt_seen = 1'b0;
    logic cmd_ready, rsp_valid, irq, par_err, idsel, gnt_n, req_n, inta_n, d_busy, id_seen, drv_l, hdrv_l;
    logic h_ad_oe, d_ad_oe, h_cbe_oe, d_cbe_oe, h_par, h_par_oe, d_par, d_par_oe, par_w, par_l;
    logic [31:0] h_ad, d_ad, d_got, ad_w, ad_l, a_seen;
    logic [3:0] h_cbe, d_cbe, cbe_w, cbe_l, c_seen, be_seen;
    wire logic [4:0] h_n, h_oe, d_n, d_oe, n_w;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    // released data lines flip every cycle; control lines have pull-ups
    assign ad_w = h_ad_oe ? h_ad : d_ad_oe ? d_ad : ~ad_l;
    assign cbe_w = h_cbe_oe ? h_cbe : d_cbe_oe ? d_cbe : ~cbe_l;
    assign par_w = h_par_oe ? h_par : d_par_oe ? d_par : ~par_l;
    assign n_w = (h_n | ~h_oe) & (d_n | ~d_oe);
    always #2 ref_clk = ~ref_clk;
    pci_host_ctrl u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .tgt_rdata(tgt_rdata), .irq(irq),
        .par_err(par_err), .ad_i(ad_w), .ad_o(h_ad), .ad_oe(h_ad_oe), .cbe_n_i(cbe_w), .cbe_n_o(h_cbe),
        .cbe_n_oe(h_cbe_oe), .par_i(par_w), .par_o(h_par), .par_oe(h_par_oe),
        .frame_n_i(n_w[4]), .frame_n_o(h_n[4]), .frame_n_oe(h_oe[4]),
        .irdy_n_i(n_w[3]), .irdy_n_o(h_n[3]), .irdy_n_oe(h_oe[3]),
        .trdy_n_i(n_w[2]), .trdy_n_o(h_n[2]), .trdy_n_oe(h_oe[2]),
        .stop_n_i(n_w[1]), .stop_n_o(h_n[1]), .stop_n_oe(h_oe[1]),
        .devsel_n_i(n_w[0]), .devsel_n_o(h_n[0]), .devsel_n_oe(h_oe[0]),
        .idsel(idsel), .req_n(req_n), .gnt_n(gnt_n), .inta_n(inta_n));
    pci_dev_model u_dev (
        .ref_clk(ref_clk), .rst_n(rst_n), .ad(ad_w), .cbe_n(cbe_w), .frame_n(n_w[4]), .irdy_n(n_w[3]),
        .trdy_n(n_w[2]), .idsel(idsel), .gnt_n(gnt_n), .mode(mode), .go(go), .go_wr(go_wr),
        .go_addr(go_addr), .go_data(go_data), .rdata(rdata), .irq_set(irq_set), .ad_o(d_ad),
        .ad_oe(d_ad_oe), .cbe_n_o(d_cbe), .cbe_oe(d_cbe_oe), .par_o(d_par), .par_oe(d_par_oe),
        .ctl_n(d_n), .ctl_oe(d_oe), .req_n(req_n), .inta_n(inta_n), .got(d_got), .busy(d_busy));
    // ----------------------------------------
    // compare and closing
    // ----------------------------------------
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // wire monitor
    // ----------------------------------------
    // parity is judged a cycle late against what the wires held
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rst_n && drv_l) chk_bit("par", ^{ad_l, cbe_l}, par_w);
        if (rst_n && drv_l) chk_bit("par_owner", hdrv_l, h_par_oe);
        if (rst_n) chk_bit("cbe_clash", 1'b0, h_cbe_oe && d_cbe_oe);
        if (rst_n) chk_bit("par_err", 1'b0, par_err);
        ad_l <= ad_w;
        cbe_l <= cbe_w;
        par_l <= par_w;
        drv_l <= h_ad_oe | d_ad_oe;
        hdrv_l <= h_ad_oe;
        if (!gnt_n) gnt_seen <= 1'b1;
        if (!n_w[4] && n_w[3]) begin
            a_seen <= ad_w;
            c_seen <= cbe_w;
            id_seen <= idsel;
        end
        if (!n_w[3] && !n_w[2]) be_seen <= cbe_w;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic host_cmd(input logic [3:0] code, input logic [3:0] be, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= '{code: code, be_n: be, addr: a, data: d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        chk_bit("cmd_taken", 1'b1, cmd_ready);
        cmd_valid <= 1'b0;
    endtask
    task automatic get_rsp(input logic [1:0] kind, input logic [31:0] d, input logic with_data);
        int n = 0;
        @(posedge ref_clk);
        rsp_ready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 60);
        chk_word("rsp_kind", 32'(kind), 32'(rsp.kind));
        if (with_data) chk_word("rsp_data", d, rsp.data);
        rsp_ready <= 1'b0;
    endtask
    task automatic dev_go(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        go <= 1'b1;
        go_wr <= wr;
        go_addr <= a;
        go_data <= d;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask
    // request must fall away before the next one
    task automatic wait_idle();
        int n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (d_busy && n < 60);
        chk_bit("dev_idle", 1'b0, d_busy);
        repeat (4) @(posedge ref_clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_codes();
        logic [3:0] codes [4] = '{pci_host_pkg::CMD_IO_RD, pci_host_pkg::CMD_IO_WR,
                                  pci_host_pkg::CMD_MEM_RD, pci_host_pkg::CMD_MEM_WR};
        logic [3:0] bes [4] = '{4'h0, 4'h5, 4'hA, 4'hE};
        logic [31:0] val;
        for (int i = 0; i < 4; i++) begin
            val = 32'h1357_9BDF + 32'(i);
            mode <= 2'(i / 2);
            rdata <= val;
            host_cmd(codes[i], bes[i], 32'hC000_0100 + 32'(4 * i), ~val);
            get_rsp(pci_host_pkg::RK_DONE, val, i % 2 == 0);
            chk_word("addr", 32'hC000_0100 + 32'(4 * i), a_seen);
            chk_word("code", 32'(codes[i]), 32'(c_seen));
            chk_word("byte_en", 32'(bes[i]), 32'(be_seen));
            if (i % 2 == 1) chk_word("wdata", ~val, d_got);
        end
    endtask
    task automatic t_cfg();
        mode <= 2'h0;
        rdata <= 32'h0BAD_CAFE;
        host_cmd(pci_host_pkg::CMD_CFG_RD, 4'h0, 32'h0000_0010, 32'h0000_0000);
        get_rsp(pci_host_pkg::RK_DONE, 32'h0BAD_CAFE, 1'b1);
        chk_bit("idsel_cfg", 1'b1, id_seen);
        host_cmd(pci_host_pkg::CMD_CFG_WR, 4'h3, 32'h0000_0014, 32'h1234_5678);
        get_rsp(pci_host_pkg::RK_DONE, 32'h0000_0000, 1'b0);
        chk_word("cfg_wdata", 32'h1234_5678, d_got);
        host_cmd(pci_host_pkg::CMD_MEM_RD, 4'h0, 32'h8000_0000, 32'h0000_0000);
        get_rsp(pci_host_pkg::RK_ABORT, 32'h0000_0000, 1'b0);
        chk_bit("idsel_mem", 1'b0, id_seen);
    endtask
    task automatic t_term();
        mode <= 2'h2;
        host_cmd(pci_host_pkg::CMD_MEM_WR, 4'h0, 32'hC000_0200, 32'h5555_AAAA);
        get_rsp(pci_host_pkg::RK_RETRY, 32'h0000_0000, 1'b0);
        chk_bit("frame_end", 1'b1, n_w[4]);
        mode <= 2'h3;
        host_cmd(pci_host_pkg::CMD_MEM_RD, 4'h0, 32'hC000_0204, 32'h0000_0000);
        get_rsp(pci_host_pkg::RK_ABORT, 32'h0000_0000, 1'b0);
    endtask
    // device reads, then three writes with the consumer stalled
    task automatic t_dev();
        tgt_rdata <= 32'hCAFE_0042;
        gnt_seen <= 1'b0;
        dev_go(1'b0, 32'h0010_0000, 32'h0000_0000);
        wait_idle();
        chk_bit("granted", 1'b1, gnt_seen);
        chk_word("dev_rdata", 32'hCAFE_0042, d_got);
        for (int i = 0; i < 3; i++) begin
            dev_go(1'b1, 32'h0010_0040, 32'hD000_0000 + 32'(i));
            if (i < 2) wait_idle();
        end
        repeat (20) @(posedge ref_clk);
        chk_bit("stalled", 1'b1, d_busy);
        chk_bit("host_refused", 1'b0, cmd_ready);
        get_rsp(pci_host_pkg::RK_TWRITE, 32'hD000_0000, 1'b1);
        wait_idle();
        get_rsp(pci_host_pkg::RK_TWRITE, 32'hD000_0001, 1'b1);
        get_rsp(pci_host_pkg::RK_TWRITE, 32'hD000_0002, 1'b1);
    endtask
    task automatic t_irq();
        irq_set <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk_bit("irq_on", 1'b1, irq);
        repeat (8) @(posedge ref_clk);
        chk_bit("irq_held", 1'b1, irq);
        irq_set <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk_bit("irq_off", 1'b0, irq);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        chk_bit("gnt_rst", 1'b1, gnt_n);
        chk_word("oe_rst", 32'h0000_0000, 32'(h_oe));
        rst_n <= 1'b1;
        t_codes();
        t_cfg();
        t_term();
        t_dev();
        t_irq();
        test_done();
    end
endmodule
